// ---- pafm_pkg.sv ----
// Package with register map, field layout and reset values of the pin-function mux.
package pafm_pkg;
   // Avalon word addresses (byte address divided by four).
   localparam logic [3:0] ADDR_SEL_WORD = 4'h0;
   localparam logic [3:0] ADDR_SEL_LOW = 4'h1;
   localparam logic [3:0] ADDR_SEL_HIGH = 4'h2;
   localparam logic [3:0] ADDR_DIR = 4'h3;
   localparam logic [3:0] ADDR_DATA = 4'h4;
   localparam logic [3:0] ADDR_CHOICE = 4'h5;
   localparam logic [3:0] ADDR_OPEN_DRAIN = 4'h6;
   localparam logic [3:0] ADDR_PIN_STATE = 4'h7;
   localparam logic [3:0] ADDR_KEY_RETURN = 4'h8;
   localparam logic [3:0] ADDR_SEL_RAW = 4'h9;

   localparam int PIN_COUNT = 16;
   localparam logic [15:0] SEL_RESET = 16'h0000;
   localparam logic [15:0] DIR_RESET = 16'hFFFF;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [3:0] BE_WORD = 4'h3;
   localparam logic [3:0] BE_BYTE0 = 4'h1;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   localparam int BYTE_W = 8;
endpackage

// ---- pafm_pin_cell.sv ----
// One shared pin: picks general I/O or alternate-function drive and output enable.
`timescale 1ns/1ps
module pafm_pin_cell (
   // Selection.
   input wire logic mode_sel,
   input wire logic choice_sel,
   input wire logic open_drain,
   // General port side.
   input wire logic port_out,
   input wire logic port_dir_in,
   // Alternate functions.
   input wire logic alt_a_out,
   input wire logic alt_a_oe,
   input wire logic alt_b_out,
   input wire logic alt_b_oe,
   // Pin.
   output logic pin_out,
   output logic pin_oe
);
   logic drv_val;
   logic drv_en;

   always_comb begin
      if (mode_sel) begin
         // Alternate function owns the pin whatever the port data and direction say.
         drv_val = choice_sel ? alt_b_out : alt_a_out; // RULE5 RULE6
         drv_en = choice_sel ? alt_b_oe : alt_a_oe; // RULE6
      end else begin
         drv_val = port_out; // RULE1
         drv_en = ~port_dir_in;
      end
      // Open drain only pulls low.
      if (open_drain) begin
         pin_out = 1'b0;
         pin_oe = drv_en & ~drv_val;
      end else begin
         pin_out = drv_val;
         pin_oe = drv_en;
      end
   end
endmodule

// ---- pafm_top.sv ----
// Address/data port function mux with Avalon-MM register slave.
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// RULE1: An address/data pin is general I/O when its select bit is 0 and bus line n when 1.
// RULE2: The whole 16-bit select register is reached only by full 16-bit reads and writes; ADDR_SEL_RAW still reads it whole under any byte enables.
// RULE3: The upper and lower bytes of the select register are also separate byte or bit registers.
// RULE4: Byte-wide access to the upper register maps select bits 8 to 15 onto its bits 0 to 7.
// RULE5: An alternate-mode pin follows its function whatever its port data and direction say.
// RULE6: Dual-function pins use the first function when the choice bit is 0 and the second when 1.
// RULE7: Key-return use needs input direction, mode, choice and open drain clear, key enable set; the code does not check open drain.
// RULE8: Open-drain never alters function selection; a real-time output needs open drain off.
// RULE9: Software sets open drain to 1 for the two-wire serial data and clock functions.
// RULE10: Software programs both edge-select bits when a pin serves as an interrupt input.
// RULE11: Software writes all direction bits of the analog output port to input in one byte write.
// RULE12: The analog input function is present on every analog port pin without any setting.
// RULE13: Software enables 16 address outputs by writing choice zero and mode all ones at once.
// RULE14: After reset every select bit is clear so every pin starts as general I/O.
module pafm_top (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // External bus controller.
   input wire logic [15:0] muxed_bus_line_out,
   input wire logic [15:0] muxed_bus_line_oe,
   output logic [15:0] muxed_bus_line_in,
   // Second alternate function per pin.
   input wire logic [15:0] alt_func_out,
   input wire logic [15:0] alt_func_oe,
   output logic [15:0] alt_func_in,
   // Port pins.
   input wire logic [15:0] addr_data_port_pin_in,
   output logic [15:0] addr_data_port_pin_out,
   output logic [15:0] addr_data_port_pin_oe,
   // Key-return input status.
   output logic [15:0] key_return_input
);
   logic [15:0] sel_q;
   logic [15:0] dir_q;
   logic [15:0] data_q;
   logic [15:0] choice_q;
   logic [15:0] od_q;
   logic [15:0] key_en_q;
   logic [15:0] pin_meta_q;
   logic [15:0] pin_sync_q;
   logic ack_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [15:0] pin_out_d;
   logic [15:0] pin_oe_d;
   logic [15:0] pin_out_q;
   logic [15:0] pin_oe_q;
   logic [15:0] bus_in_q;
   logic [15:0] alt_in_q;
   logic [15:0] key_q;
   logic access;
   logic wr_take;

   // Merge written bytes into a 16-bit register under byte enables.
   // Lanes 2 and 3 are ignored, since no register here is wider than 16 bits.
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      merge16 = old;
      if (be[0]) merge16[7:0] = wd[7:0];
      if (be[1]) merge16[15:8] = wd[15:8];
   endfunction

   // Either direction starts the same single wait state.
   assign access = avs_read | avs_write;
   // One wait state: the request is accepted on the edge where ack_q is high.
   assign avs_waitrequest = wait_q;
   // A write lands only on the edge at which waitrequest is low.
   assign wr_take = avs_write & ack_q;

   // Waitrequest has its own flop, always the inverse of ack_q.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         wait_q <= 1'b1;
      end else begin
         ack_q <= access & ~ack_q;
         wait_q <= ~(access & ~ack_q);
      end
   end

   // Select register: whole-word only when full 16 bits enabled, plus byte views.
   // A partial write to the whole-word view is dropped rather than merged.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sel_q <= pafm_pkg::SEL_RESET; // RULE14
      end else if (wr_take) begin
         case (avs_address)
            pafm_pkg::ADDR_SEL_WORD: begin
               if (avs_byteenable == pafm_pkg::BE_WORD) sel_q <= avs_writedata[15:0]; // RULE2
            end
            pafm_pkg::ADDR_SEL_LOW: begin
               if (avs_byteenable[0]) sel_q[7:0] <= avs_writedata[7:0]; // RULE3
            end
            pafm_pkg::ADDR_SEL_HIGH: begin
               if (avs_byteenable[0]) sel_q[15:8] <= avs_writedata[7:0]; // RULE3 RULE4
            end
            default: begin
            end
         endcase
      end
   end

   // Port configuration registers.
   // Direction bit 1 means input, so every pin comes out of reset undriven.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dir_q <= pafm_pkg::DIR_RESET;
         data_q <= pafm_pkg::ZERO16;
         choice_q <= pafm_pkg::ZERO16;
         od_q <= pafm_pkg::ZERO16;
         key_en_q <= pafm_pkg::ZERO16;
      end else if (wr_take) begin
         case (avs_address)
            pafm_pkg::ADDR_DIR: dir_q <= merge16(dir_q, avs_writedata, avs_byteenable);
            pafm_pkg::ADDR_DATA: data_q <= merge16(data_q, avs_writedata, avs_byteenable);
            pafm_pkg::ADDR_CHOICE: begin
               choice_q <= merge16(choice_q, avs_writedata, avs_byteenable);
            end
            pafm_pkg::ADDR_OPEN_DRAIN: od_q <= merge16(od_q, avs_writedata, avs_byteenable);
            pafm_pkg::ADDR_KEY_RETURN: begin
               key_en_q <= merge16(key_en_q, avs_writedata, avs_byteenable);
            end
            default: begin
            end
         endcase
      end
   end

   // Read data is captured on the first edge of a read, while waitrequest is still high,
   // so it stands at the edge where the master takes it.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_q <= pafm_pkg::UNMAPPED_READ;
      end else if (avs_read & ~ack_q) begin
         rdata_q <= pafm_pkg::UNMAPPED_READ;
         case (avs_address)
            pafm_pkg::ADDR_SEL_WORD: begin
               if (avs_byteenable == pafm_pkg::BE_WORD) rdata_q[15:0] <= sel_q; // RULE2
            end
            pafm_pkg::ADDR_SEL_LOW: rdata_q[7:0] <= sel_q[7:0]; // RULE3
            pafm_pkg::ADDR_SEL_HIGH: rdata_q[7:0] <= sel_q[15:8]; // RULE4
            pafm_pkg::ADDR_DIR: rdata_q[15:0] <= dir_q;
            pafm_pkg::ADDR_DATA: rdata_q[15:0] <= data_q;
            pafm_pkg::ADDR_CHOICE: rdata_q[15:0] <= choice_q;
            pafm_pkg::ADDR_OPEN_DRAIN: rdata_q[15:0] <= od_q;
            // Pin state reads back whatever the direction, mode and choice bits say.
            pafm_pkg::ADDR_PIN_STATE: rdata_q[15:0] <= pin_sync_q; // RULE12
            pafm_pkg::ADDR_KEY_RETURN: rdata_q[15:0] <= key_en_q;
            pafm_pkg::ADDR_SEL_RAW: rdata_q[15:0] <= sel_q;
            // Unmapped words read as zero.
            default: rdata_q <= pafm_pkg::UNMAPPED_READ;
         endcase
      end
   end
   assign avs_readdata = rdata_q;

   // Per-pin steering; open drain is applied after selection so it never changes it.
   for (genvar i = 0; i < pafm_pkg::PIN_COUNT; i++) begin : g_pin
      pafm_pin_cell u_cell (
         .mode_sel(sel_q[i]),
         .choice_sel(choice_q[i]),
         .open_drain(od_q[i]), // RULE8
         .port_out(data_q[i]),
         .port_dir_in(dir_q[i]),
         .alt_a_out(muxed_bus_line_out[i]),
         .alt_a_oe(muxed_bus_line_oe[i]),
         .alt_b_out(alt_func_out[i]),
         .alt_b_oe(alt_func_oe[i]),
         .pin_out(pin_out_d[i]),
         .pin_oe(pin_oe_d[i])
      );
   end

   // Pin inputs cross two flip-flops before use.
   // Only pin_sync_q feeds logic; pin_meta_q may still be settling.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_meta_q <= pafm_pkg::ZERO16;
         pin_sync_q <= pafm_pkg::ZERO16;
      end else begin
         pin_meta_q <= addr_data_port_pin_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   // Registered pin drive and function inputs.
   // The registered copy keeps pin drive free of glitches when several bits change at once.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_out_q <= pafm_pkg::ZERO16;
         pin_oe_q <= pafm_pkg::ZERO16;
         bus_in_q <= pafm_pkg::ZERO16;
         alt_in_q <= pafm_pkg::ZERO16;
         key_q <= pafm_pkg::ZERO16;
      end else begin
         pin_out_q <= pin_out_d;
         pin_oe_q <= pin_oe_d;
         // Function inputs are masked, so a peripheral that is not selected sees zero.
         bus_in_q <= pin_sync_q & sel_q & ~choice_q; // RULE1 RULE5
         alt_in_q <= pin_sync_q & sel_q & choice_q; // RULE6
         // Key return works when software set the pin up as a plain input.
         key_q <= pin_sync_q & key_en_q & dir_q & ~sel_q & ~choice_q; // RULE7
      end
   end
   // Every output leaves the block straight from a flop.
   assign addr_data_port_pin_out = pin_out_q;
   assign addr_data_port_pin_oe = pin_oe_q;
   assign muxed_bus_line_in = bus_in_q;
   assign alt_func_in = alt_in_q;
   assign key_return_input = key_q;
endmodule

// ---- pafm_top_properties.sv ----
// Port assertions for the address/data port function mux.
`timescale 1ns/1ps
module pafm_top_properties (
   // Clock, reset and register bus.
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Pins and function inputs.
   input wire logic [15:0] muxed_bus_line_in,
   input wire logic [15:0] alt_func_in,
   input wire logic [15:0] addr_data_port_pin_in,
   input wire logic [15:0] addr_data_port_pin_oe,
   input wire logic [15:0] key_return_input
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic rd_ack = avs_read & ~avs_waitrequest;
   reset_idle_a: assert property ($rose(rst_n) |-> avs_waitrequest && avs_readdata == 32'h0 &&
      addr_data_port_pin_oe == 16'h0) else $error("outputs not idle after reset");
   ack_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2]
      !avs_waitrequest) else $error("request not acknowledged in time");
   ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge longer than one cycle");
   ack_cause_a: assert property (!avs_waitrequest |-> avs_read || avs_write)
      else $error("acknowledge without request");
   word_lanes_a: assert property (rd_ack && avs_address == pafm_pkg::ADDR_SEL_WORD &&
      avs_byteenable != pafm_pkg::BE_WORD |-> avs_readdata == 32'h0)
      else $error("partial word read returned data");
   byte_width_a: assert property (rd_ack && (avs_address == pafm_pkg::ADDR_SEL_LOW ||
      avs_address == pafm_pkg::ADDR_SEL_HIGH) |-> avs_readdata[31:8] == 24'h0)
      else $error("byte register read too wide");
   unmapped_zero_a: assert property (rd_ack && avs_address > pafm_pkg::ADDR_SEL_RAW |->
      avs_readdata == 32'h0) else $error("unmapped read returned data");
   fn_exclusive_a: assert property ((muxed_bus_line_in & alt_func_in) == 16'h0)
      else $error("both functions sample one pin");
   key_gpio_a: assert property ((key_return_input & (muxed_bus_line_in | alt_func_in)) == 16'h0)
      else $error("key input on a function pin");
   fn_source_a: assert property (((muxed_bus_line_in | alt_func_in) &
      ~$past(addr_data_port_pin_in, 3)) == 16'h0) else $error("function input not from pin");
endmodule
bind pafm_top pafm_top_properties pafm_top_properties_inst (.ref_clk, .rst_n, .avs_address,
   .avs_read, .avs_write, .avs_byteenable, .avs_readdata, .avs_waitrequest, .muxed_bus_line_in,
   .alt_func_in, .addr_data_port_pin_in, .addr_data_port_pin_oe, .key_return_input);

// ---- pafm_far_side.sv ----
// Behavioural bus controller and second-function peripheral.
`timescale 1ns/1ps
module pafm_far_side (
   // Clock, reset and pattern to drive.
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [15:0] pattern,
   // Function drive.
   output logic [15:0] bus_out,
   output logic [15:0] bus_oe,
   output logic [15:0] alt_out,
   output logic [15:0] alt_oe
);
   always_ff @(posedge ref_clk) begin
      bus_out <= rst_n ? pattern : 16'h0000;
      bus_oe <= rst_n ? ~pattern : 16'h0000;
      alt_out <= rst_n ? ~pattern : 16'h0000;
      alt_oe <= rst_n ? pattern : 16'h0000;
   end
endmodule

// ---- pafm_top_tb.sv ----
// Self-checking bench for the address/data port function mux.
`timescale 1ns/1ps
module pafm_top_tb;
   logic ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'hE08E1121, expq[$];
   logic [15:0] pin_in = 16'h0, pat = 16'h0, v, p_out, p_oe, b_in, a_in, k_in, b_o, b_e, a_o, a_e;
   int miscompares = 0, checks_done = 0;
   pafm_far_side pafm_far_side_inst (.ref_clk, .rst_n, .pattern(pat), .bus_out(b_o),
      .bus_oe(b_e), .alt_out(a_o), .alt_oe(a_e));
   pafm_top pafm_top_inst (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .muxed_bus_line_out(b_o),
      .muxed_bus_line_oe(b_e), .muxed_bus_line_in(b_in), .alt_func_out(a_o), .alt_func_oe(a_e),
      .alt_func_in(a_in), .addr_data_port_pin_in(pin_in), .addr_data_port_pin_out(p_out),
      .addr_data_port_pin_oe(p_oe), .key_return_input(k_in));
   always #10 ref_clk = ~ref_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // A read notes its expected data; the monitor compares it at the acknowledge.
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be = pafm_pkg::BE_WORD);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      if (!wr) expq.push_back(d);
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic pins(input logic [15:0] o, oe, bi, ai, ki);
      repeat (4) @(posedge ref_clk);
      check("pin_out", {16'h0, p_out}, {16'h0, o});
      check("pin_oe", {16'h0, p_oe}, {16'h0, oe});
      check("bus_in", {16'h0, b_in}, {16'h0, bi});
      check("alt_in", {16'h0, a_in}, {16'h0, ai});
      check("key_in", {16'h0, k_in}, {16'h0, ki});
   endtask
   task automatic final_report();
      if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      if (rst_n && avs_read && avs_waitrequest === 1'b0 && expq.size() > 0) begin
         check("readdata", avs_readdata, expq.pop_front());
      end
   end
   initial begin
      #200000;
      miscompares++;
      final_report();
   end
   initial begin
      seed = lfsr(seed);
      v = seed[15:0];
      seed = lfsr(seed);
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      pat <= seed[15:0];
      pin_in <= seed[31:16];
      @(posedge ref_clk);
      av(0, pafm_pkg::ADDR_SEL_WORD, {16'h0, pafm_pkg::SEL_RESET});
      av(0, pafm_pkg::ADDR_DIR, {16'h0, pafm_pkg::DIR_RESET});
      av(1, pafm_pkg::ADDR_SEL_WORD, {16'h0, v});
      av(0, pafm_pkg::ADDR_SEL_LOW, {24'h0, v[7:0]}, pafm_pkg::BE_BYTE0);
      av(0, pafm_pkg::ADDR_SEL_HIGH, {24'h0, v[15:8]}, pafm_pkg::BE_BYTE0);
      av(1, pafm_pkg::ADDR_SEL_WORD, 32'h0, pafm_pkg::BE_BYTE0);
      av(0, pafm_pkg::ADDR_SEL_WORD, {16'h0, v});
      av(0, pafm_pkg::ADDR_SEL_WORD, 32'h0, pafm_pkg::BE_BYTE0);
      av(1, pafm_pkg::ADDR_SEL_HIGH, 32'hA5, pafm_pkg::BE_BYTE0);
      av(1, pafm_pkg::ADDR_SEL_LOW, 32'h3C, pafm_pkg::BE_BYTE0);
      av(0, pafm_pkg::ADDR_SEL_WORD, 32'hA53C);
      av(1, 4'hF, 32'hFFFF);
      av(0, 4'hF, 32'h0);
      av(1, pafm_pkg::ADDR_DIR, 32'h0);
      av(1, pafm_pkg::ADDR_DATA, {16'h0, v});
      av(1, pafm_pkg::ADDR_SEL_WORD, 32'h0);
      pins(v, 16'hFFFF, 16'h0, 16'h0, 16'h0);
      av(1, pafm_pkg::ADDR_CHOICE, 32'h0);
      av(1, pafm_pkg::ADDR_SEL_WORD, 32'hFFFF);
      av(0, pafm_pkg::ADDR_SEL_RAW, 32'hFFFF);
      av(0, pafm_pkg::ADDR_PIN_STATE, {16'h0, pin_in});
      pins(pat, ~pat, pin_in, 16'h0, 16'h0);
      av(1, pafm_pkg::ADDR_CHOICE, 32'hFFFF);
      pins(~pat, pat, 16'h0, pin_in, 16'h0);
      av(1, pafm_pkg::ADDR_OPEN_DRAIN, 32'hFFFF);
      pins(16'h0, pat, 16'h0, pin_in, 16'h0);
      av(1, pafm_pkg::ADDR_CHOICE, 32'h0);
      pins(16'h0, ~pat, pin_in, 16'h0, 16'h0);
      av(1, pafm_pkg::ADDR_SEL_WORD, 32'h0);
      av(1, pafm_pkg::ADDR_OPEN_DRAIN, 32'h0);
      av(1, pafm_pkg::ADDR_DIR, 32'hFFFF);
      av(1, pafm_pkg::ADDR_KEY_RETURN, 32'hFFFF);
      pins(v, 16'h0, 16'h0, 16'h0, pin_in);
      av(0, pafm_pkg::ADDR_KEY_RETURN, 32'hFFFF);
      av(0, pafm_pkg::ADDR_DATA, {16'h0, v});
      av(1, pafm_pkg::ADDR_DIR, 32'h0);
      av(1, pafm_pkg::ADDR_DIR, 32'hFF, pafm_pkg::BE_BYTE0);
      av(0, pafm_pkg::ADDR_DIR, 32'hFF);
      final_report();
   end
endmodule
